// >>> core/sfo_defs.svh
// Constants of the supervisor input filter and output mux block.
// Assumes a 10 MHz core clock and a classic Wishbone slave with 32-bit data.
//
// Behaviour
// - Undervoltage fault holds until input rises above threshold plus hysteresis.
// - Overvoltage fault holds until input falls below threshold minus hysteresis.
// - Hysteresis is a 5-bit code up to 31, in range/255 steps.
// - Each detector output passes a glitch filter, timeout up to 100 us.
// - Pulses shorter than the timeout never reach the filter output.
// - Longer pulses pass, delayed by the programmed timeout.
// - Warning detector uses the range of the primary detector on that supply.
// - Warnings are readable as status and ORed into one sequencer warning.
// - Digital input selects level or edge mode; level output follows the input.
// - Edge mode emits a pulse on each selected edge (rising, falling or both), width 0 to 100 us.
// - Digital inputs pass the same programmable glitch filter.
// - Digital inputs have a selectable weak pull-down enable.
// - Sequencer decides driver values from detectors, digital inputs and warning.
// - Each driver has a drive style; charge pump only on outputs one to six.
// - Each driver takes data from sequencer, bus value or internal clock.
// - In bus control the host writes the value and the driver follows it.
// - An internal 100 kHz clock can be routed to any driver.
// - Until configuration is latched, drivers stay in weak pull-down state.
// - Drivers actively low once any supply reaches 1 V, high impedance before.
// - A dual input is analog detector or digital input, never both.
`ifndef SFO_DEFS_SVH
`define SFO_DEFS_SVH
`define SFO_CLK_HZ        10000000
`define SFO_TICK_US       1
`define SFO_CYC_PER_US    (`SFO_CLK_HZ / 1000000 * `SFO_TICK_US)
`define SFO_GLITCH_MAX_US 100
`define SFO_PULSE_MAX_US  100
`define SFO_CLKOUT_HZ     100000
`define SFO_CLKOUT_HALF   (`SFO_CLK_HZ / `SFO_CLKOUT_HZ / 2)
`define SFO_ADR_CTRL      8'h00
`define SFO_ADR_STATUS    8'h04
`define SFO_ADR_CH_BASE   8'h40
`define SFO_ADR_MODE_BASE 8'h80
`define SFO_ADR_DRV_BASE  8'hC0
`define SFO_CH_UVTH_LSB   0
`define SFO_CH_OVTH_LSB   8
`define SFO_CH_HYST_LSB   16
`define SFO_CH_GLITCH_LSB 24
`define SFO_MD_UVEN_BIT   0
`define SFO_MD_OVEN_BIT   1
`define SFO_MD_RANGE_LSB  2
`define SFO_MD_EDGE_LSB   4
`define SFO_MD_EDGEMODE   6
`define SFO_MD_PULLDN     7
`define SFO_MD_WIDTH_LSB  8
`define SFO_DRV_SRC_LSB   0
`define SFO_DRV_STYLE_LSB 2
`define SFO_DRV_VAL_BIT   5
`define SFO_CH_RST        32'h0000_FF00
`define SFO_MD_RST        32'h0000_0003
`define SFO_DRV_RST       32'h0000_0000
`endif

// >>> core/sfo_pkg.sv
// Types of the supervisor input filter and output mux block.
// Assumes sfo_defs.svh for the numeric constants.
package sfo_pkg;
   typedef enum logic [1:0] {SFO_SRC_SEQ = 2'h0, SFO_SRC_BUS = 2'h1, SFO_SRC_CLK = 2'h2} sfo_src_e;
   typedef enum logic [2:0] {
      SFO_STY_OD     = 3'h0,
      SFO_STY_OD_PUD = 3'h1,
      SFO_STY_PP_VDD = 3'h2,
      SFO_STY_OD_PUP = 3'h3,
      SFO_STY_PP_VP  = 3'h4,
      SFO_STY_PD     = 3'h5,
      SFO_STY_CPUMP  = 3'h6,
      SFO_STY_WEAKPD = 3'h7
   } sfo_style_e;
   typedef enum logic [1:0] {SFO_EDGE_BOTH = 2'h0, SFO_EDGE_RISE = 2'h1, SFO_EDGE_FALL = 2'h2} sfo_edge_e;
endpackage

// >>> core/sfo_top.sv
// Supply fault detector conditioning, dual input logic and driver output mux.
// Assumes comparator codes on the core clock, pins from outside, Wishbone classic.
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "sfo_defs.svh"
module sfo_top
   import sfo_pkg::*;
#(
   parameter int NCH  = 10,
   parameter int NDUAL = 5,
   parameter int NDRV = 10,
   parameter int NCPUMP = 6
) (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // Wishbone slave
   input  wire logic                cyc_i,
   input  wire logic                stb_i,
   input  wire logic                we_i,
   input  wire logic [7:0]          adr_i,
   input  wire logic [3:0]          sel_i,
   input  wire logic [31:0]         dat_i,
   output logic      [31:0]         dat_o,
   output logic                     ack_o,
   // Analog front end
   input  wire logic [8*NCH-1:0]    volt_code_i,
   output logic      [2*NCH-1:0]    range_sel_o,
   input  wire logic                supply_1v_i,
   // Dual function pins
   input  wire logic [NDUAL-1:0]    dual_pin_i,
   output logic      [NDUAL-1:0]    weak_pd_en_o,
   // Sequencer side
   output logic      [NCH-1:0]      fault_o,
   output logic      [NDUAL-1:0]    din_o,
   output logic                     warn_any_o,
   input  wire logic [NDRV-1:0]     seq_drv_i,
   // Driver pins
   output logic      [NDRV-1:0]     drv_out_o,
   output logic      [NDRV-1:0]     drv_oe_o,
   output logic      [3*NDRV-1:0]   drv_style_o
);

   localparam int NF = NCH + NDUAL;

   function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
      end
      return r;
   endfunction

   // Microsecond code to cycles, clamped at the documented maximum
   function automatic logic [10:0] us_cycles(input logic [6:0] code, input logic [6:0] maxc);
      logic [6:0] c;
      c = (code > maxc) ? maxc : code;
      return 11'(c * `SFO_CYC_PER_US);
   endfunction

   // Registers
   logic [31:0] ch_cfg   [NCH];
   logic [31:0] md_cfg   [NCH];
   logic [31:0] drv_cfg  [NDRV];
   logic        cfg_latched;
   logic [NDUAL-1:0] dig_sel;

   // Bus decode
   wire         bus_req   = cyc_i && stb_i && !ack_o;
   wire         wr_req    = bus_req && we_i;
   wire [3:0]   reg_idx   = adr_i[5:2];
   wire [1:0]   reg_grp   = adr_i[7:6];
   wire         idx_ch    = 32'(reg_idx) < NCH;
   wire         idx_drv   = 32'(reg_idx) < NDRV;
   wire         hit_ctrl  = adr_i == `SFO_ADR_CTRL;
   wire         hit_stat  = adr_i == `SFO_ADR_STATUS;
   wire         hit_ch    = reg_grp == `SFO_ADR_CH_BASE >> 6 && idx_ch;
   wire         hit_md    = reg_grp == `SFO_ADR_MODE_BASE >> 6 && idx_ch;
   wire         hit_drv   = reg_grp == `SFO_ADR_DRV_BASE >> 6 && idx_drv;
   wire         ctrl_sel  = !adr_i[7] && !adr_i[6] && (hit_ctrl || hit_stat);

   // Pin synchronisers
   logic [NDUAL-1:0] pin_m, pin_s;
   logic             sup_m, sup_s;
   always_ff @(posedge clk_i) begin
      pin_m <= dual_pin_i;
      pin_s <= pin_m;
      sup_m <= supply_1v_i;
      sup_s <= sup_m;
   end

   // Detector input selection and hysteresis comparators
   logic [NCH-1:0] uv_st, ov_st;
   logic [7:0]     mon_code [NCH];
   logic [8:0]     uv_rel   [NCH];
   logic [NCH-1:0] next_uv, next_ov, raw_det;
   always_comb begin
      for (int k = 0; k < NCH; k++) begin
         // Digital dual input: detector watches the mapped supply
         if (k >= NDUAL && dig_sel[k-NDUAL])
            mon_code[k] = volt_code_i[8*(k-NDUAL) +: 8];
         else
            mon_code[k] = volt_code_i[8*k +: 8];
         uv_rel[k]  = 9'(ch_cfg[k][`SFO_CH_UVTH_LSB +: 8]) + 9'(ch_cfg[k][`SFO_CH_HYST_LSB +: 5]);
         // Release only above threshold plus hysteresis; zero code releases one code above threshold
         next_uv[k] = uv_st[k] ? ({1'b0, mon_code[k]} <= uv_rel[k])
                               : (mon_code[k] < ch_cfg[k][`SFO_CH_UVTH_LSB +: 8]);
         // Release only below threshold minus hysteresis
         next_ov[k] = ov_st[k] ? (9'(mon_code[k]) + 9'(ch_cfg[k][`SFO_CH_HYST_LSB +: 5])
                                  >= 9'(ch_cfg[k][`SFO_CH_OVTH_LSB +: 8]))
                               : (mon_code[k] > ch_cfg[k][`SFO_CH_OVTH_LSB +: 8]);
         raw_det[k] = (uv_st[k] && md_cfg[k][`SFO_MD_UVEN_BIT]) || (ov_st[k] && md_cfg[k][`SFO_MD_OVEN_BIT]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         uv_st <= '0;
         ov_st <= '0;
      end else begin
         uv_st <= next_uv;
         ov_st <= next_ov;
      end
   end

   // Glitch filters: detectors then digital pins, same timeout code
   logic [NF-1:0]  gf_in, gf_out;
   logic [10:0]    gf_cnt [NF];
   logic [10:0]    gf_lim [NF];
   always_comb begin
      for (int f = 0; f < NF; f++) begin
         if (f < NCH) begin
            gf_in[f]  = raw_det[f];
            gf_lim[f] = us_cycles(ch_cfg[f][`SFO_CH_GLITCH_LSB +: 7], 7'(`SFO_GLITCH_MAX_US));
         end else begin
            gf_in[f]  = pin_s[f-NCH];
            gf_lim[f] = us_cycles(ch_cfg[f-NDUAL][`SFO_CH_GLITCH_LSB +: 7], 7'(`SFO_GLITCH_MAX_US));
         end
      end
   end

   // Output flips only after the input differed for the whole timeout
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gf_out <= '0;
         for (int f = 0; f < NF; f++) gf_cnt[f] <= '0;
      end else begin
         for (int f = 0; f < NF; f++) begin
            if (gf_in[f] == gf_out[f]) begin
               gf_cnt[f] <= '0;
            end else if (gf_cnt[f] + 11'h001 >= gf_lim[f]) begin
               gf_out[f] <= gf_in[f];
               gf_cnt[f] <= '0;
            end else begin
               gf_cnt[f] <= gf_cnt[f] + 11'h001;
            end
         end
      end
   end

   // Fault and warning split
   logic [NCH-1:0]   fault_w;
   logic [NDUAL-1:0] warn_w;
   always_comb begin
      for (int k = 0; k < NCH; k++) begin
         fault_w[k] = gf_out[k] && !(k >= NDUAL && dig_sel[k-NDUAL]);
      end
      for (int j = 0; j < NDUAL; j++) begin
         warn_w[j] = gf_out[NDUAL + j] && dig_sel[j];
      end
   end

   // Digital input level or edge blocks
   logic [NDUAL-1:0] dfilt_d, pulse_on, next_din, edge_hit;
   logic [10:0]      pulse_cnt [NDUAL];
   logic [10:0]      pulse_lim [NDUAL];
   always_comb begin
      for (int j = 0; j < NDUAL; j++) begin
         case (md_cfg[NDUAL+j][`SFO_MD_EDGE_LSB +: 2])
            SFO_EDGE_RISE: edge_hit[j] = gf_out[NCH+j] && !dfilt_d[j];
            SFO_EDGE_FALL: edge_hit[j] = !gf_out[NCH+j] && dfilt_d[j];
            default:       edge_hit[j] = gf_out[NCH+j] != dfilt_d[j];
         endcase
         pulse_lim[j] = us_cycles(md_cfg[NDUAL+j][`SFO_MD_WIDTH_LSB +: 7], 7'(`SFO_PULSE_MAX_US));
         // Level mode follows the filtered input
         next_din[j]  = md_cfg[NDUAL+j][`SFO_MD_EDGEMODE] ? pulse_on[j] : gf_out[NCH+j];
      end
   end

   // Pulse restarts on each selected edge, zero width gives a single cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dfilt_d  <= '0;
         pulse_on <= '0;
         for (int j = 0; j < NDUAL; j++) pulse_cnt[j] <= '0;
      end else begin
         dfilt_d <= gf_out[NCH +: NDUAL];
         for (int j = 0; j < NDUAL; j++) begin
            if (edge_hit[j]) begin
               pulse_on[j]  <= 1'b1;
               pulse_cnt[j] <= 11'h001;
            end else if (pulse_on[j] && pulse_cnt[j] < pulse_lim[j]) begin
               pulse_cnt[j] <= pulse_cnt[j] + 11'h001;
            end else begin
               pulse_on[j]  <= 1'b0;
            end
         end
      end
   end

   // 100 kHz internal clock
   logic [15:0] div_cnt;
   logic        clk100;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt <= '0;
         clk100  <= 1'b0;
      end else if (div_cnt == 16'(`SFO_CLKOUT_HALF - 1)) begin
         div_cnt <= '0;
         clk100  <= !clk100;
      end else begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end

   // Driver data source and drive style
   logic [NDRV-1:0]   next_out, next_oe;
   logic [3*NDRV-1:0] next_style;
   logic              drv_dat;
   logic [2:0]        sty;
   always_comb begin
      drv_dat = 1'b0;
      sty     = SFO_STY_WEAKPD;
      for (int n = 0; n < NDRV; n++) begin
         // Exactly one source, code 3 falls back to the sequencer
         case (drv_cfg[n][`SFO_DRV_SRC_LSB +: 2])
            SFO_SRC_BUS: drv_dat = drv_cfg[n][`SFO_DRV_VAL_BIT];
            SFO_SRC_CLK: drv_dat = clk100;
            default:     drv_dat = seq_drv_i[n];
         endcase
         sty = drv_cfg[n][`SFO_DRV_STYLE_LSB +: 3];
         if (!cfg_latched) begin
            // Weak pull-down until latched; active low once a supply is up
            next_style[3*n +: 3] = SFO_STY_WEAKPD;
            next_out[n]          = 1'b0;
            next_oe[n]           = sup_s;
         end else begin
            next_style[3*n +: 3] = sty;
            case (sty)
               SFO_STY_PP_VDD, SFO_STY_PP_VP, SFO_STY_CPUMP: begin
                  next_out[n] = drv_dat;
                  next_oe[n]  = 1'b1;
               end
               SFO_STY_PD: begin
                  next_out[n] = 1'b0;
                  next_oe[n]  = !drv_dat;
               end
               SFO_STY_WEAKPD: begin
                  next_out[n] = 1'b0;
                  next_oe[n]  = sup_s;
               end
               default: begin
                  next_out[n] = 1'b0;
                  next_oe[n]  = !drv_dat;
               end
            endcase
         end
      end
   end

   // Range for the front end: warning detector shares the primary range
   logic [2*NCH-1:0] next_range;
   always_comb begin
      for (int k = 0; k < NCH; k++) begin
         if (k >= NDUAL && dig_sel[k-NDUAL])
            next_range[2*k +: 2] = md_cfg[k-NDUAL][`SFO_MD_RANGE_LSB +: 2];
         else if (k >= NDUAL)
            next_range[2*k +: 2] = 2'h0;
         else
            next_range[2*k +: 2] = md_cfg[k][`SFO_MD_RANGE_LSB +: 2];
      end
   end

   // Read mux
   logic [31:0] rd_val;
   always_comb begin
      rd_val = 32'h0000_0000;
      if (hit_ctrl)
         rd_val = {19'h0, dig_sel, 7'h0, cfg_latched};
      else if (hit_stat)
         rd_val = {11'h000, din_o, warn_any_o, warn_w, fault_w};
      else if (hit_ch && !ctrl_sel)
         rd_val = ch_cfg[reg_idx];
      else if (hit_md)
         rd_val = md_cfg[reg_idx];
      else if (hit_drv)
         rd_val = drv_cfg[reg_idx];
   end

   // Register writes; unmapped addresses ack with zero data
   logic [31:0] dwr;
   assign dwr = hit_drv ? wmask(drv_cfg[reg_idx], dat_i, sel_i) : 32'h0000_0000;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o       <= 1'b0;
         dat_o       <= '0;
         cfg_latched <= 1'b0;
         dig_sel     <= '0;
         for (int k = 0; k < NCH; k++) begin
            ch_cfg[k] <= `SFO_CH_RST;
            md_cfg[k] <= `SFO_MD_RST;
         end
         for (int n = 0; n < NDRV; n++) drv_cfg[n] <= `SFO_DRV_RST;
      end else begin
         ack_o <= bus_req;
         dat_o <= bus_req ? rd_val : 32'h0000_0000;
         if (wr_req && hit_ctrl) begin
            if (sel_i[0] && dat_i[0]) cfg_latched <= 1'b1;
            if (sel_i[1]) dig_sel <= dat_i[12:8];
         end
         if (wr_req && hit_ch && !ctrl_sel) ch_cfg[reg_idx] <= wmask(ch_cfg[reg_idx], dat_i, sel_i);
         if (wr_req && hit_md) md_cfg[reg_idx] <= wmask(md_cfg[reg_idx], dat_i, sel_i);
         if (wr_req && hit_drv) begin
            drv_cfg[reg_idx] <= dwr;
            // Charge pump refused on outputs seven and up, falls back to open drain
            if (32'(reg_idx) >= NCPUMP && dwr[`SFO_DRV_STYLE_LSB +: 3] == SFO_STY_CPUMP)
               drv_cfg[reg_idx][`SFO_DRV_STYLE_LSB +: 3] <= SFO_STY_OD;
         end
      end
   end

   // Output registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_o      <= '0;
         din_o        <= '0;
         warn_any_o   <= 1'b0;
         weak_pd_en_o <= '0;
         range_sel_o  <= '0;
         drv_out_o    <= '0;
         drv_oe_o     <= '0;
         drv_style_o  <= {NDRV{SFO_STY_WEAKPD}};
      end else begin
         fault_o     <= fault_w;
         din_o       <= next_din & dig_sel;
         warn_any_o  <= |warn_w;
         for (int j = 0; j < NDUAL; j++) begin
            weak_pd_en_o[j] <= dig_sel[j] && md_cfg[NDUAL+j][`SFO_MD_PULLDN];
         end
         range_sel_o <= next_range;
         drv_out_o   <= next_out;
         drv_oe_o    <= next_oe;
         drv_style_o <= next_style;
      end
   end

   // Checks
   ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   uv_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      uv_st[0] && {1'b0, mon_code[0]} <= uv_rel[0] |=> uv_st[0])
      else $error("undervoltage released below threshold plus hysteresis");
   ov_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ov_st[0] && 9'(mon_code[0]) + 9'(ch_cfg[0][20:16]) >= 9'(ch_cfg[0][15:8]) |=> ov_st[0])
      else $error("overvoltage released above threshold minus hysteresis");
   glitch_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(gf_out[0]) |-> $past(gf_cnt[0]) + 11'h001 >= $past(gf_lim[0]) && $past(gf_in[0]) == gf_out[0])
      else $error("filter output changed before the timeout");
   glitch_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
      gf_in[0] != gf_out[0] && gf_cnt[0] + 11'h001 >= gf_lim[0] |=> gf_out[0] == $past(gf_in[0]))
      else $error("filter output missed a long pulse");
   warn_or_a: assert property (@(posedge clk_i) disable iff (rst_i)
      |warn_w |=> warn_any_o)
      else $error("warning not forwarded");
   clk_div_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(clk100) |-> $past(div_cnt) == 16'(`SFO_CLKOUT_HALF - 1))
      else $error("internal clock toggled off its count");
   pre_cfg_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !cfg_latched |=> drv_style_o == {NDRV{SFO_STY_WEAKPD}} && drv_out_o == '0)
      else $error("driver left weak pull-down before latch");
   hiz_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !cfg_latched |=> drv_oe_o == {NDRV{$past(sup_s)}})
      else $error("driver enable wrong before latch");
   cpump_lim_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_latched |=> drv_style_o[3*NCPUMP +: 3] != SFO_STY_CPUMP)
      else $error("charge pump on an output that lacks it");
endmodule

// >>> verif/sfo_far_model.sv
// Far side model: monitored rails, dual pins and a minimal sequencer.
// Assumes the bench sets rail codes and pin levels; everything runs on clk_i.
`timescale 1ns/1ps
module sfo_far_model (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Bench controls
   input  wire logic [79:0] rail_code_i,
   input  wire logic [4:0]  pin_lvl_i,
   input  wire logic [4:0]  pin_float_i,
   input  wire logic        rail_up_i,
   // Block side
   input  wire logic [9:0]  fault_i,
   input  wire logic [4:0]  weak_pd_en_i,
   output logic      [79:0] volt_code_o,
   output logic      [4:0]  dual_pin_o,
   output logic             supply_1v_o,
   output logic      [9:0]  seq_drv_o
);
   logic [4:0] last_pin;
   always_ff @(posedge clk_i) begin
      volt_code_o <= rail_code_i;
      supply_1v_o <= rail_up_i;
      // Driver 1 enabled only while rail 0 is good
      seq_drv_o   <= rst_i ? 10'h000 : {8'h00, ~fault_i[0], 1'b0};
      last_pin    <= rst_i ? 5'h00 : dual_pin_o;
   end
   // Floating pin sinks low with pull-down, otherwise wanders
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         dual_pin_o[i] = pin_float_i[i] ? (weak_pd_en_i[i] ? 1'b0 : ~last_pin[i]) : pin_lvl_i[i];
      end
   end
endmodule

// >>> verif/supervisor_input_filter_output_mux_tb_top.sv
// Bench for sfo_top: Wishbone tasks, rail and pin stimulus, checked scenarios.
// Assumes sfo_far_model stands for rails, pins and sequencer.
`timescale 1ns/1ps
module supervisor_input_filter_output_mux_tb_top;
   logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, up = 0, ack, warn, s1v, seen;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, dat_o;
   logic [79:0] rail = {10{8'h60}}, codes;
   logic [4:0]  plvl = 5'h00, pflt = 5'h01, pins, pd, din;
   logic [9:0]  fault, seq, dout, doe;
   logic [19:0] rng;
   logic [29:0] sty;
   int          mismatches = 0, compares = 0, n;
   always #50 clk = ~clk;
   sfo_top u_sfo_top (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack), .volt_code_i(codes), .range_sel_o(rng),
      .supply_1v_i(s1v), .dual_pin_i(pins), .weak_pd_en_o(pd), .fault_o(fault), .din_o(din),
      .warn_any_o(warn), .seq_drv_i(seq), .drv_out_o(dout), .drv_oe_o(doe), .drv_style_o(sty));
   sfo_far_model u_sfo_far_model (.clk_i(clk), .rst_i(rst), .rail_code_i(rail), .pin_lvl_i(plvl),
      .pin_float_i(pflt), .rail_up_i(up), .fault_i(fault), .weak_pd_en_i(pd), .volt_code_o(codes),
      .dual_pin_o(pins), .supply_1v_o(s1v), .seq_drv_o(seq));
   task automatic finish_test;
      $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
   endtask
   // One classic cycle; request held until ack sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         mismatches++;
         finish_test();
      end
   endtask
   task automatic rail0(input logic [7:0] c, input logic e);
      rail[7:0] <= c;
      tick(6);
      chk(fault[0], e, "fault state");
   endtask
   task automatic t_reset;
      chk(sty, {10{3'h7}}, "style before latch");
      chk(doe, 10'h000, "drive below 1 V");
      up <= 1'b1;
      tick(5);
      chk(doe, 10'h3FF, "drive at 1 V");
      chk(dout, 10'h000, "held low");
      $display("test reset done");
   endtask
   task automatic t_hyst;
      wb(1'b1, 8'h40, 32'h0004_FF50);
      rail0(8'h40, 1'b1);
      rail0(8'h54, 1'b1);
      rail0(8'h55, 1'b0);
      wb(1'b1, 8'h40, 32'h0000_FF50);
      rail0(8'h40, 1'b1);
      rail0(8'h51, 1'b0);
      wb(1'b1, 8'h40, 32'h0004_8050);
      rail0(8'h81, 1'b1);
      rail0(8'h7C, 1'b1);
      rail0(8'h7B, 1'b0);
      rail0(8'h60, 1'b0);
      $display("test hysteresis done");
   endtask
   task automatic t_glitch;
      wb(1'b1, 8'h40, 32'h0204_FF50);
      rail[7:0] <= 8'h40;
      tick(10);
      rail[7:0] <= 8'h60;
      seen = 1'b0;
      repeat (40) begin
         @(posedge clk);
         seen = seen | fault[0];
      end
      chk(seen, 0, "short pulse passed");
      rail[7:0] <= 8'h40;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (fault[0] !== 1'b1 && n < 100);
      chk(n >= 20 && n <= 26, 1, "filter delay");
      if (n >= 100) finish_test();
      rail[7:0] <= 8'h60;
      tick(40);
      $display("test glitch done");
   endtask
   task automatic t_drv;
      wb(1'b1, 8'h00, 32'h0000_0001);
      wb(1'b1, 8'hC0, 32'h0000_0029);
      wb(1'b1, 8'hC4, 32'h0000_0008);
      wb(1'b1, 8'hC8, 32'h0000_000A);
      wb(1'b1, 8'hD4, 32'h0000_0019);
      wb(1'b1, 8'hD8, 32'h0000_0019);
      tick(3);
      chk({doe[0], dout[0]}, 2'h3, "bus value high");
      chk(dout[1], 1'b1, "sequencer value");
      chk(sty[17:15], 3'h6, "charge pump on 6");
      chk(sty[20:18], 3'h0, "charge pump on 7");
      wb(1'b0, 8'hD8, 32'h0);
      chk(rdat, 32'h0000_0001, "coerced style readback");
      wb(1'b0, 8'h3C, 32'h0);
      chk(rdat, 32'h0, "unmapped read");
      wb(1'b1, 8'hC0, 32'h0000_0009);
      tick(3);
      chk(dout[0], 1'b0, "bus value low");
      for (int h = 0; h < 2; h++) begin
         seen = dout[2];
         n = 0;
         while (dout[2] === seen && n < 120) begin
            @(posedge clk);
            n++;
         end
      end
      chk(n, 50, "clock half period");
      if (n >= 120) finish_test();
      $display("test drivers done");
   endtask
   task automatic t_dual;
      wb(1'b1, 8'h00, 32'h0000_0101);
      wb(1'b1, 8'h80, 32'h0000_000B);
      wb(1'b1, 8'h94, 32'h0000_0083);
      wb(1'b1, 8'h54, 32'h0000_FF50);
      tick(4);
      chk(pd[0], 1'b1, "pull-down on");
      chk(din[0], 1'b0, "floating pin low");
      chk(rng[11:10], 2'h2, "warning range");
      chk(fault[5], 1'b0, "no analog fault");
      pflt[0] <= 1'b0;
      plvl[0] <= 1'b1;
      tick(6);
      chk(din[0], 1'b1, "level follows");
      rail[7:0] <= 8'h40;
      tick(6);
      chk(warn, 1'b1, "warning ORed");
      wb(1'b0, 8'h04, 32'h0);
      chk(rdat[10], 1'b1, "warning status");
      rail[7:0] <= 8'h60;
      wb(1'b1, 8'h94, 32'h0000_01C3);
      tick(10);
      plvl[0] <= 1'b0;
      n = 0;
      repeat (40) begin
         @(posedge clk);
         n += (din[0] === 1'b1);
      end
      chk(n, 10, "edge pulse width");
      // Short pin pulse under a 1 us filter must give no edge
      wb(1'b1, 8'h54, 32'h0100_FF50);
      plvl[0] <= 1'b1;
      tick(5);
      plvl[0] <= 1'b0;
      n = 0;
      repeat (30) begin
         @(posedge clk);
         n += (din[0] === 1'b1);
      end
      chk(n, 0, "short pin pulse passed");
      $display("test dual input done");
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_hyst();
      t_glitch();
      t_drv();
      t_dual();
      finish_test();
   end
endmodule
